//--- hw/comparator_cd_threshold_regs.sv
// ahb-lite register bank for comparators c and d and the two threshold codes
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module comparator_cd_threshold_regs (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic comp_c_raw_zero_in,
   input wire logic comp_c_raw_ext_in,
   input wire logic comp_d_raw_zero_in,
   input wire logic comp_d_raw_ext_in,
   output logic comp_c_enable_out,
   output logic comp_c_threshold_select_out,
   output logic comp_d_enable_out,
   output logic comp_d_threshold_select_out,
   output logic [7:0] threshold_level_zero_out,
   output logic [7:0] threshold_level_one_out,
   output logic comp_c_status_out,
   output logic comp_d_status_out,
   output logic comp_c_irq_event_out,
   output logic comp_d_irq_event_out
);
   import cmp_cd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, one write address latched into the data phase
   logic [7:0] config_reg, config_next;
   logic [7:0] thr0_reg, thr0_next;
   logic [7:0] thr1_reg, thr1_next;
   logic wr_pend_reg, wr_pend_next;
   logic [31:0] wr_addr_reg, wr_addr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic addr_phase;

   function automatic logic [7:0] read_mux(input logic [31:0] a, input logic [7:0] c,
                                           input logic [7:0] z, input logic [7:0] o);
      read_mux = REG_RESET;
      if (a == CONFIG_CD_BYTE) read_mux = c;
      else if (a == THRESH_ZERO_BYTE) read_mux = z;
      else if (a == THRESH_ONE_BYTE) read_mux = o;
   endfunction

   always_comb begin
      addr_phase = hsel_in & hready_in & htrans_in[1];
      config_next = config_reg;
      thr0_next = thr0_reg;
      thr1_next = thr1_reg;
      // low byte holds the register; each register owns one aligned word
      if (wr_pend_reg) begin
         if (wr_addr_reg == CONFIG_CD_BYTE) config_next = hwdata_in[7:0];
         if (wr_addr_reg == THRESH_ZERO_BYTE) thr0_next = hwdata_in[7:0];
         if (wr_addr_reg == THRESH_ONE_BYTE) thr1_next = hwdata_in[7:0];
      end
      wr_pend_next = addr_phase & hwrite_in;
      wr_addr_next = addr_phase ? haddr_in : wr_addr_reg;
      rdata_next = RDATA_ZERO;
      // reads see registers as updated by a write in the same cycle's data phase
      if (addr_phase & ~hwrite_in) begin
         rdata_next = {24'h00_0000,
                       read_mux(haddr_in, config_next, thr0_next, thr1_next)};
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         config_reg <= REG_RESET;
         thr0_reg <= REG_RESET;
         thr1_reg <= REG_RESET;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 32'h0000_0000;
         rdata_reg <= RDATA_ZERO;
      end else begin
         config_reg <= config_next;
         thr0_reg <= thr0_next;
         thr1_reg <= thr1_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         rdata_reg <= rdata_next;
      end
   end

   assign hrdata_out = rdata_reg;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // analog controls straight from the register flops
   // settle time after enable is software's job; nothing here holds the output off
   assign comp_c_enable_out = config_reg[C_ENABLE_BIT];
   assign comp_c_threshold_select_out = config_reg[C_THSEL_BIT];
   assign comp_d_enable_out = config_reg[D_ENABLE_BIT];
   assign comp_d_threshold_select_out = config_reg[D_THSEL_BIT];
   assign threshold_level_zero_out = thr0_reg;
   assign threshold_level_one_out = thr1_reg;

   ////////////////////////////////////////////////////////////////////////////
   // channels
   comp_channel chan_c (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .enable_in(config_reg[C_ENABLE_BIT]),
      .threshold_select_in(config_reg[C_THSEL_BIT]),
      .irq_enable_in(config_reg[C_IRQEN_BIT]),
      .invert_in(config_reg[C_INVERT_BIT]),
      .raw_at_zero_in(comp_c_raw_zero_in),
      .raw_at_ext_in(comp_c_raw_ext_in),
      .status_out(comp_c_status_out),
      .irq_event_out(comp_c_irq_event_out)
   );
   comp_channel chan_d (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .enable_in(config_reg[D_ENABLE_BIT]),
      .threshold_select_in(config_reg[D_THSEL_BIT]),
      .irq_enable_in(config_reg[D_IRQEN_BIT]),
      .invert_in(config_reg[D_INVERT_BIT]),
      .raw_at_zero_in(comp_d_raw_zero_in),
      .raw_at_ext_in(comp_d_raw_ext_in),
      .status_out(comp_d_status_out),
      .irq_event_out(comp_d_irq_event_out)
   );
endmodule // comparator_cd_threshold_regs

//--- hw/cmp_cd_pkg.sv
// constants and register map for the comparator c/d control bank
package cmp_cd_pkg;
   localparam logic [15:0] CONFIG_CD_ADDR = 16'ha031;
   localparam logic [15:0] THRESH_ZERO_ADDR = 16'ha032;
   localparam logic [15:0] THRESH_ONE_ADDR = 16'ha033;
   // printed offsets are word indices: not all are multiples of four, so the bus address is 4x
   localparam logic [31:0] CONFIG_CD_BYTE = {14'h0000, CONFIG_CD_ADDR, 2'b00};
   localparam logic [31:0] THRESH_ZERO_BYTE = {14'h0000, THRESH_ZERO_ADDR, 2'b00};
   localparam logic [31:0] THRESH_ONE_BYTE = {14'h0000, THRESH_ONE_ADDR, 2'b00};
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int C_ENABLE_BIT = 7;
   localparam int C_THSEL_BIT = 6;
   localparam int C_IRQEN_BIT = 5;
   localparam int C_INVERT_BIT = 4;
   localparam int D_ENABLE_BIT = 3;
   localparam int D_THSEL_BIT = 2;
   localparam int D_IRQEN_BIT = 1;
   localparam int D_INVERT_BIT = 0;
   localparam real SETTLE_US = 20.0;
   localparam real CLK_MHZ = 20.0;
   localparam int SETTLE_CYCLES = int'($ceil(SETTLE_US * CLK_MHZ));
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

//--- hw/comp_channel.sv
// one comparator channel: threshold mux, polarity, gating and edge event
`timescale 1ns/1ps
module comp_channel (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic enable_in,
   input wire logic threshold_select_in,
   input wire logic irq_enable_in,
   input wire logic invert_in,
   input wire logic raw_at_zero_in,
   input wire logic raw_at_ext_in,
   output logic status_out,
   output logic irq_event_out
);
   logic status_reg, status_next;
   logic event_reg, event_next;
   logic sel_raw;
   always_comb begin
      sel_raw = threshold_select_in ? raw_at_ext_in : raw_at_zero_in;
      status_next = enable_in & (sel_raw ^ invert_in);
      // edges only count while enabled, so the forced-low on disable raises nothing
      event_next = enable_in & irq_enable_in & (status_next ^ status_reg);
   end
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         status_reg <= 1'b0;
         event_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         event_reg <= event_next;
      end
   end
   assign status_out = status_reg;
   assign irq_event_out = event_reg;
endmodule // comp_channel

//--- testbench/cmp_cd_sva.sv
// checker for the comparator c/d register bank
`timescale 1ns/1ps
module cmp_cd_sva import cmp_cd_pkg::*; (
   input wire logic mclk_in, sys_rst_in, hsel_in, hwrite_in, hready_in,
   input wire logic [31:0] haddr_in, hwdata_in, hrdata_out,
   input wire logic [1:0] htrans_in,
   input wire logic comp_c_enable_out, comp_c_threshold_select_out, comp_d_enable_out,
   input wire logic comp_d_threshold_select_out, comp_c_status_out, comp_d_status_out,
   input wire logic comp_c_irq_event_out,
   input wire logic [7:0] threshold_level_zero_out, threshold_level_one_out
);
   logic ph_reg, wr_reg;
   logic [31:0] adr_reg;
   // data-phase view of the bus, so writes are checked where they land
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ph_reg <= 1'b0;
         wr_reg <= 1'b0;
         adr_reg <= 32'h0000_0000;
      end else begin
         ph_reg <= hsel_in & hready_in & htrans_in[1];
         wr_reg <= hwrite_in;
         adr_reg <= haddr_in;
      end
   end
   wire wc = ph_reg & wr_reg & (adr_reg == CONFIG_CD_BYTE);
   wire wz = ph_reg & wr_reg & (adr_reg == THRESH_ZERO_BYTE);
   wire wo = ph_reg & wr_reg & (adr_reg == THRESH_ONE_BYTE);
   wire rz = ph_reg & ~wr_reg & (adr_reg == THRESH_ZERO_BYTE);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   a_c_enable_wr: assert property (wc |=> comp_c_enable_out == $past(hwdata_in[7]))
      else $error("c enable not written");
   a_c_select_wr: assert property (wc |=> comp_c_threshold_select_out == $past(hwdata_in[6]))
      else $error("c select not written");
   a_d_enable_wr: assert property (wc |=> comp_d_enable_out == $past(hwdata_in[3]))
      else $error("d enable not written");
   a_d_select_wr: assert property (wc |=> comp_d_threshold_select_out == $past(hwdata_in[2]))
      else $error("d select not written");
   a_zero_code_wr: assert property (wz |=> threshold_level_zero_out == $past(hwdata_in[7:0]))
      else $error("zero code not written");
   a_one_code_wr: assert property (wo |=> threshold_level_one_out == $past(hwdata_in[7:0]))
      else $error("one code not written");
   a_zero_code_hold: assert property (!wz |=> $stable(threshold_level_zero_out))
      else $error("zero code moved without write");
   a_zero_read_back: assert property (rz |-> hrdata_out == {24'h00_0000, threshold_level_zero_out})
      else $error("zero code read back wrong");
   a_c_off_low: assert property (!comp_c_enable_out |=> !comp_c_status_out)
      else $error("c status high while off");
   a_d_off_low: assert property (!comp_d_enable_out |=> !comp_d_status_out)
      else $error("d status high while off");
   c_zero_wr: cover property (wz);
   c_c_event: cover property (comp_c_irq_event_out);
   c_d_status: cover property (comp_d_status_out);
endmodule // cmp_cd_sva
bind comparator_cd_threshold_regs cmp_cd_sva u_cmp_cd_sva (.*);

//--- testbench/comparator_cd_threshold_regs_tb_top.sv
// self-checking bench for the comparator c/d register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module comparator_cd_threshold_regs_tb_top;
   import cmp_cd_pkg::*;
   logic mclk_in = 0, sys_rst_in = 1, hsel_in = 0, hwrite_in = 0, hready_in, hreadyout_out, hresp_out;
   logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out, q;
   logic [1:0] htrans_in = 0;
   logic [2:0] hsize_in = HSIZE_WORD;
   logic comp_c_raw_zero_in = 0, comp_c_raw_ext_in = 0, comp_d_raw_zero_in = 0, comp_d_raw_ext_in = 0;
   logic comp_c_enable_out, comp_c_threshold_select_out, comp_d_enable_out;
   logic comp_d_threshold_select_out, comp_c_status_out, comp_d_status_out;
   logic comp_c_irq_event_out, comp_d_irq_event_out;
   logic [7:0] threshold_level_zero_out, threshold_level_one_out;
   logic [7:0] pat [4] = '{8'hcc, 8'h33, 8'hff, 8'h00};
   logic [7:0] cf [7] = '{8'h88, 8'h88, 8'hcc, 8'hcc, 8'hdd, 8'h99, 8'h00};
   logic [1:0] rw [7] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b10, 2'b10, 2'b11};
   logic ex [7] = '{1, 0, 1, 0, 1, 0, 0};
   int bad_count = 0, tests_run = 0, cyc = 0, ev = 0, evd = 0;
   assign hready_in = hreadyout_out;
   comparator_cd_threshold_regs u_comparator_cd_threshold_regs (.*);
   initial forever #25 mclk_in = ~mclk_in;
   // a hang ends the run well past the planned length
   always @(posedge mclk_in) begin
      cyc++;
      ev += (comp_c_irq_event_out === 1'b1);
      evd += (comp_d_irq_event_out === 1'b1);
      if (cyc == 8000) begin bad_count++; close_out(); end
   end
   task close_out;
      $display("tests %0d bad %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      hsel_in <= 1; haddr_in <= a; htrans_in <= HTRANS_NONSEQ; hwrite_in <= w;
      do @(posedge mclk_in); while (hready_in !== 1'b1);
      hsel_in <= 0; htrans_in <= 2'b00; hwdata_in <= {24'h00_0000, d};
      do @(posedge mclk_in); while (hready_in !== 1'b1);
      q = hrdata_out;
   endtask
   task rd(input logic [31:0] a, input logic [7:0] e);
      xfer(0, a, 8'h00);
      `CHK("rdata", {24'h00_0000, e}, q)
      `CHK("hresp", 1'b0, hresp_out)
      `CHK("hready", 1'b1, hreadyout_out)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge mclk_in);
      sys_rst_in <= 0;
      rd(CONFIG_CD_BYTE, 8'h00);
      rd(THRESH_ZERO_BYTE, 8'h00);
      rd(THRESH_ONE_BYTE, 8'h00);
      foreach (pat[i]) begin
         xfer(1, CONFIG_CD_BYTE, pat[i]);
         xfer(1, THRESH_ZERO_BYTE, pat[i]);
         xfer(1, THRESH_ONE_BYTE, ~pat[i]);
         @(negedge mclk_in);
         `CHK("c_en", pat[i][7], comp_c_enable_out)
         `CHK("c_sel", pat[i][6], comp_c_threshold_select_out)
         `CHK("d_en", pat[i][3], comp_d_enable_out)
         `CHK("d_sel", pat[i][2], comp_d_threshold_select_out)
         `CHK("zero", pat[i], threshold_level_zero_out)
         `CHK("one", ~pat[i], threshold_level_one_out)
         rd(CONFIG_CD_BYTE, pat[i]);
         rd(THRESH_ONE_BYTE, ~pat[i]);
      end
      xfer(1, 32'h0002_80d0, 8'h5a);
      rd(32'h0002_80d0, 8'h00);
      $display("test registers done");
      foreach (cf[i]) begin
         xfer(1, CONFIG_CD_BYTE, cf[i]);
         {comp_c_raw_zero_in, comp_c_raw_ext_in, comp_d_raw_zero_in, comp_d_raw_ext_in} <= {rw[i], rw[i]};
         repeat (3) @(negedge mclk_in);
         `CHK("c_stat", ex[i], comp_c_status_out)
         `CHK("d_stat", ex[i], comp_d_status_out)
      end
      $display("test status done");
      foreach (cf[k]) begin
         if (k < 2) begin
            xfer(1, CONFIG_CD_BYTE, k ? 8'h88 : 8'haa);
            repeat (SETTLE_CYCLES) @(posedge mclk_in);
            ev = 0;
            evd = 0;
            repeat (4) begin
               @(posedge mclk_in);
               comp_c_raw_zero_in <= ~comp_c_raw_zero_in;
               comp_d_raw_zero_in <= ~comp_d_raw_zero_in;
               repeat (4) @(posedge mclk_in);
            end
            `CHK("c_events", k ? 0 : 4, ev)
            `CHK("d_events", k ? 0 : 4, evd)
         end
      end
      $display("test events done");
      close_out();
   end
endmodule // comparator_cd_threshold_regs_tb_top
